// ---- hdl/reg_set_remap_sp.sv ----
// Register-set remap of the legacy operand names plus the 24-bit stack pointer
`timescale 1ns/100ps
module reg_set_remap_sp
	import reg_remap_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Status word low byte
	input wire logic pswWrEn,
	input wire logic [PSW_LOW_W-1:0] pswWrData,
	output logic [PSW_LOW_W-1:0] status_word_low_byte_r,
	output logic register_set_select_flag_r,
	// General register access
	input wire logic regReq,
	input wire logic regWr,
	input wire operand_kind_t regKind,
	input wire use_ctx_t regCtx,
	input wire logic [BYTE_SEL_W-1:0] regSel,
	input wire logic [WORD_W-1:0] regWrData,
	output logic [WORD_W-1:0] regRdData_r,
	output logic regRdValid_r,
	output logic [BYTE_SEL_W-1:0] regPhysSel_r,
	output logic regPhysWide_r,
	// Stack pointer load
	input wire logic spLoad,
	input wire logic [SP_W-1:0] spLoadData,
	output logic [SP_W-1:0] stack_top_pointer_r,
	// Stack operations
	input wire logic pushReq,
	input wire logic popReq,
	input wire logic stackWide,
	output logic [SP_W-1:0] stackAddr_r,
	output logic stackWrStb_r,
	output logic stackRdStb_r,
	output logic stackWideOut_r,
	output logic stackBusy_r
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstSync1_r;
	logic rstSync2_r;
	logic rstN;

	// Two-stage release so every flop reset by rstN leaves reset on the same edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end

	assign rstN = rstSync2_r;

	// ----------------------------------------------------------------
	// Status word low byte
	// ----------------------------------------------------------------
	logic [PSW_LOW_W-1:0] pswLowNxt;
	logic register_set_select_flag;

	// Fixed-zero bit is forced so a careless write cannot set it
	always_comb begin
		pswLowNxt = pswWrData;
		pswLowNxt[PSW_FIXED_ZERO_POS] = 1'b0;
	end

	// Cleared by reset so the default mapping is in force at start
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			status_word_low_byte_r <= PSW_LOW_RESET;
		end else if (pswWrEn) begin
			status_word_low_byte_r <= pswLowNxt;
		end
	end

	assign register_set_select_flag = status_word_low_byte_r[RSS_POS];

	// Separate copy of the flag for the output port, kept in step with the byte; the decoder reads the bit in the byte
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			register_set_select_flag_r <= PSW_LOW_RESET[RSS_POS];
		end else if (pswWrEn) begin
			register_set_select_flag_r <= pswLowNxt[RSS_POS];
		end
	end

	// ----------------------------------------------------------------
	// Operand remap
	// ----------------------------------------------------------------
	logic remapCtx;
	logic [BYTE_SEL_W-1:0] physByte;
	logic [WORD_SEL_W-1:0] physWord;
	logic physWide;

	// Only the three legacy uses follow the select flag
	assign remapCtx = (regCtx != CTX_OTHER);

	// Function and absolute names to one physical byte or word number
	always_comb begin
		physByte = regSel;
		physWord = regSel[WORD_SEL_W-1:0];
		physWide = 1'b0;
		case (regKind)
			OP_ABS_BYTE: begin
				physByte = regSel;
			end
			OP_ABS_WORD: begin
				physWide = 1'b1;
				physWord = regSel[WORD_SEL_W-1:0];
			end
			OP_FUNC_BYTE: begin
				if (regSel > FUNC_BYTE_REMAP_LAST) begin
					// E, D, L, H do not move with the flag
					physByte = regSel + FUNC_BYTE_HIGH_OFS;
				end else if (register_set_select_flag && remapCtx) begin
					physByte = regSel + RSS1_BYTE_OFS;
				end else begin
					physByte = regSel;
				end
			end
			OP_FUNC_WORD: begin
				physWide = 1'b1;
				if (regSel[WORD_SEL_W-1:0] > FUNC_WORD_REMAP_LAST) begin
					physWord = regSel[WORD_SEL_W-1:0];
				end else if (register_set_select_flag && remapCtx) begin
					physWord = regSel[WORD_SEL_W-1:0] + RSS1_WORD_OFS;
				end else begin
					physWord = regSel[WORD_SEL_W-1:0];
				end
			end
			default: begin
				physByte = regSel;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Register bank access
	// ----------------------------------------------------------------
	logic [WORD_SEL_W-1:0] bankAddr;
	logic [1:0] bankByteEn;
	logic [WORD_W-1:0] bankWrData;
	logic [WORD_W-1:0] bankRdData;
	logic rdPend_r;
	logic rdWide_r;
	logic rdHigh_r;

	// Byte n lives in word n/2, odd bytes in the upper lane
	always_comb begin
		if (physWide) begin
			bankAddr = physWord;
			bankByteEn = 2'h3;
			bankWrData = regWrData;
		end else begin
			bankAddr = physByte[BYTE_SEL_W-1:1];
			bankByteEn = physByte[0] ? 2'h2 : 2'h1;
			bankWrData = {regWrData[BYTE_W-1:0], regWrData[BYTE_W-1:0]};
		end
	end

	gpr_word_bank bank (
		.clk(ref_clk),
		.wrEn(regReq && regWr),
		.wrByteEn(bankByteEn),
		.wrAddr(bankAddr),
		.wrData(bankWrData),
		.rdEn(regReq && !regWr),
		.rdAddr(bankAddr),
		.rdData_r(bankRdData)
	);

	// Read pipeline tracking which lane to return
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rdPend_r <= 1'b0;
			rdWide_r <= 1'b0;
			rdHigh_r <= 1'b0;
		end else begin
			rdPend_r <= regReq && !regWr;
			rdWide_r <= physWide;
			rdHigh_r <= physByte[0];
		end
	end

	// Byte reads return in the low lane with the upper byte zero
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			regRdData_r <= 16'h0000;
			regRdValid_r <= 1'b0;
		end else begin
			regRdValid_r <= rdPend_r;
			if (rdPend_r) begin
				if (rdWide_r) begin
					regRdData_r <= bankRdData;
				end else if (rdHigh_r) begin
					regRdData_r <= {8'h00, bankRdData[WORD_W-1:BYTE_W]};
				end else begin
					regRdData_r <= {8'h00, bankRdData[BYTE_W-1:0]};
				end
			end
		end
	end

	// Physical target of the last access, for observation
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			regPhysSel_r <= 4'h0;
			regPhysWide_r <= 1'b0;
		end else if (regReq) begin
			regPhysSel_r <= physWide ? {1'b0, physWord} : physByte;
			regPhysWide_r <= physWide;
		end
	end

	// ----------------------------------------------------------------
	// Stack sequencer
	// ----------------------------------------------------------------
	stack_state_t stackState_r;
	logic [SP_W-1:0] step;
	logic pushTake;
	logic popTake;
	logic loadTake;
	logic popWide_r;

	assign step = stackWide ? STEP_WORD : STEP_BYTE;
	// Load beats push beats pop; requests while busy are dropped
	assign loadTake = (stackState_r == ST_IDLE) && spLoad;
	// No check on the pointer: an undefined pointer is still used
	assign pushTake = (stackState_r == ST_IDLE) && !spLoad && pushReq;
	assign popTake = (stackState_r == ST_IDLE) && !spLoad && !pushReq && popReq;

	// One-cycle write or read phase after each accepted push or pop; a load adds no phase
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			stackState_r <= ST_IDLE;
		end else begin
			case (stackState_r)
				ST_IDLE: begin
					if (pushTake) begin
						stackState_r <= ST_PUSH_WR;
					end else if (popTake) begin
						stackState_r <= ST_POP_RD;
					end
				end
				ST_PUSH_WR: begin
					stackState_r <= ST_IDLE;
				end
				ST_POP_RD: begin
					stackState_r <= ST_IDLE;
				end
				default: begin
					stackState_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Pointer has no reset on purpose: it stays undefined until loaded
	always_ff @(posedge ref_clk) begin
		if (loadTake) begin
			stack_top_pointer_r <= spLoadData;
		end else if (pushTake) begin
			stack_top_pointer_r <= stack_top_pointer_r - step;
		end else if (stackState_r == ST_POP_RD) begin
			stack_top_pointer_r <= stack_top_pointer_r + (popWide_r ? STEP_WORD : STEP_BYTE);
		end
	end

	// Wide flag kept for the increment after the read

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			popWide_r <= 1'b0;
		end else if (popTake) begin
			popWide_r <= stackWide;
		end
	end

	// Address, strobes and width seen by the memory side
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			stackAddr_r <= 24'h000000;
			stackWrStb_r <= 1'b0;
			stackRdStb_r <= 1'b0;
			stackWideOut_r <= 1'b0;
		end else begin
			stackWrStb_r <= pushTake;
			stackRdStb_r <= popTake;
			if (pushTake) begin
				// Write goes to the already decremented address
				stackAddr_r <= stack_top_pointer_r - step;
				stackWideOut_r <= stackWide;
			end else if (popTake) begin
				stackAddr_r <= stack_top_pointer_r;
				stackWideOut_r <= stackWide;
			end
		end
	end

	// Busy while the write or read phase runs
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			stackBusy_r <= 1'b0;
		end else begin
			stackBusy_r <= pushTake || popTake;
		end
	end

endmodule // reg_set_remap_sp

// ---- hdl/reg_remap_pkg.sv ----
// Shared constants and types for the register-set remap and stack pointer block
package reg_remap_pkg;

	// ----------------------------------------------------------------
	// Status word low byte
	// ----------------------------------------------------------------
	localparam int PSW_LOW_W = 8;
	localparam logic [PSW_LOW_W-1:0] PSW_LOW_RESET = 8'h00;
	localparam int RSS_POS = 5;
	localparam int PSW_FIXED_ZERO_POS = 1;

	// ----------------------------------------------------------------
	// General register bank
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int GPR_WORDS = 8;
	localparam int BYTE_SEL_W = 4;
	localparam int WORD_SEL_W = 3;
	// Offset added to the byte group when the select flag is 1
	localparam logic [BYTE_SEL_W-1:0] RSS1_BYTE_OFS = 4'h4;
	// Offset added to the pair group when the select flag is 1
	localparam logic [WORD_SEL_W-1:0] RSS1_WORD_OFS = 3'h2;
	// Function codes 4..7 (E, D, L, H) sit at R12..R15
	localparam logic [BYTE_SEL_W-1:0] FUNC_BYTE_HIGH_OFS = 4'h8;
	// Function byte codes: 0 aux, 1 accumulator, 2 counter low, 3 counter high
	localparam logic [BYTE_SEL_W-1:0] FUNC_BYTE_REMAP_LAST = 4'h3;
	// Function word codes: 0 accumulator word, 1 counter pair
	localparam logic [WORD_SEL_W-1:0] FUNC_WORD_REMAP_LAST = 3'h1;

	// ----------------------------------------------------------------
	// Stack pointer
	// ----------------------------------------------------------------
	localparam int SP_W = 24;
	localparam logic [SP_W-1:0] STEP_BYTE = 24'h000001;
	localparam logic [SP_W-1:0] STEP_WORD = 24'h000002;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CTX_EXPLICIT = 2'h0,
		CTX_IMPLIED = 2'h1,
		CTX_INDEX = 2'h2,
		CTX_OTHER = 2'h3
	} use_ctx_t;

	typedef enum logic [1:0] {
		OP_ABS_BYTE = 2'h0,
		OP_ABS_WORD = 2'h1,
		OP_FUNC_BYTE = 2'h2,
		OP_FUNC_WORD = 2'h3
	} operand_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PUSH_WR = 3'h2,
		ST_POP_RD = 3'h4
	} stack_state_t;

endpackage

// ---- hdl/gpr_word_bank.sv ----
// General register bank memory: 8 words of 16 bits, byte write enables, registered read
`timescale 1ns/100ps
module gpr_word_bank
	import reg_remap_pkg::*;
(
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wrEn,
	input wire logic [1:0] wrByteEn,
	input wire logic [WORD_SEL_W-1:0] wrAddr,
	input wire logic [WORD_W-1:0] wrData,
	// Read port
	input wire logic rdEn,
	input wire logic [WORD_SEL_W-1:0] rdAddr,
	output logic [WORD_W-1:0] rdData_r
);

	logic [WORD_W-1:0] mem [GPR_WORDS];

	// Byte-lane writes; the bank holds data only, so no reset is needed
	always_ff @(posedge clk) begin
		if (wrEn && wrByteEn[0]) begin
			mem[wrAddr][BYTE_W-1:0] <= wrData[BYTE_W-1:0];
		end
		if (wrEn && wrByteEn[1]) begin
			mem[wrAddr][WORD_W-1:BYTE_W] <= wrData[WORD_W-1:BYTE_W];
		end
	end

	// Registered read, old data on a same-cycle collision
	always_ff @(posedge clk) begin
		if (rdEn) begin
			rdData_r <= mem[rdAddr];
		end
	end

endmodule // gpr_word_bank

// ---- tb/reg_remap_asserts.sv ----
// Checker for the register remap and stack pointer block
`timescale 1ns/100ps
module reg_remap_chk
	import reg_remap_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Status and register access
	input wire logic pswWrEn,
	input wire logic [PSW_LOW_W-1:0] pswWrData,
	input wire logic [PSW_LOW_W-1:0] status_word_low_byte_r,
	input wire logic register_set_select_flag_r,
	input wire logic regReq,
	input wire logic regWr,
	input wire operand_kind_t regKind,
	input wire use_ctx_t regCtx,
	input wire logic [BYTE_SEL_W-1:0] regSel,
	input wire logic regRdValid_r,
	input wire logic [BYTE_SEL_W-1:0] regPhysSel_r,
	// Stack
	input wire logic spLoad,
	input wire logic [SP_W-1:0] spLoadData,
	input wire logic [SP_W-1:0] stack_top_pointer_r,
	input wire logic pushReq,
	input wire logic popReq,
	input wire logic stackWide,
	input wire logic [SP_W-1:0] stackAddr_r,
	input wire logic stackWrStb_r,
	input wire logic stackRdStb_r,
	input wire logic stackBusy_r
);
	// ----------------------------------------------------------------
	// Helpers and properties
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// Pointer has no reset, so address checks wait for a first load
	logic spSeen_r;
	wire takeLd = spLoad && !stackBusy_r;
	wire takePush = pushReq && !spLoad && !stackBusy_r;
	wire takePop = popReq && !pushReq && !spLoad && !stackBusy_r;
	wire funcLow = regReq && regSel <= FUNC_BYTE_REMAP_LAST;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			spSeen_r <= 1'b0;
		else if (takeLd)
			spSeen_r <= 1'b1;
	end

	property p_psw_wr;
		pswWrEn |=> status_word_low_byte_r == ($past(pswWrData) & 8'hFD)
			&& register_set_select_flag_r == $past(pswWrData[RSS_POS]);
	endproperty
	a_psw_wr: assert property (p_psw_wr) else $error("status byte write wrong");
	property p_remap_byte;
		funcLow && regKind == OP_FUNC_BYTE && regCtx != CTX_OTHER
			|=> regPhysSel_r == $past(regSel) + ($past(register_set_select_flag_r) ? 4'h4 : 4'h0);
	endproperty
	a_remap_byte: assert property (p_remap_byte) else $error("byte remap wrong");
	property p_remap_word;
		funcLow && regKind == OP_FUNC_WORD && regSel[3:1] == 3'h0 && regCtx != CTX_OTHER
			|=> regPhysSel_r == $past(regSel) + ($past(register_set_select_flag_r) ? 4'h2 : 4'h0);
	endproperty
	a_remap_word: assert property (p_remap_word) else $error("word remap wrong");
	property p_other;
		funcLow && regKind == OP_FUNC_BYTE && regCtx == CTX_OTHER |=> regPhysSel_r == $past(regSel);
	endproperty
	a_other: assert property (p_other) else $error("unremapped use moved");
	property p_abs;
		regReq && regKind == OP_ABS_BYTE |=> regPhysSel_r == $past(regSel);
	endproperty
	a_abs: assert property (p_abs) else $error("absolute byte moved");
	property p_rd_valid;
		regReq && !regWr |-> ##2 regRdValid_r;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
	property p_push;
		takePush |=> stackWrStb_r && stackBusy_r && !stackRdStb_r;
	endproperty
	a_push: assert property (p_push) else $error("push not taken");
	property p_push_addr;
		takePush && spSeen_r |=> stackAddr_r == stack_top_pointer_r
			&& stack_top_pointer_r == $past(stack_top_pointer_r) - ($past(stackWide) ? 24'h2 : 24'h1);
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("push address wrong");
	property p_pop;
		takePop && spSeen_r |=> stackRdStb_r && stackAddr_r == $past(stack_top_pointer_r)
			##1 stack_top_pointer_r == $past(stackAddr_r) + ($past(stackWide, 2) ? 24'h2 : 24'h1);
	endproperty
	a_pop: assert property (p_pop) else $error("pop sequence wrong");
	property p_load;
		takeLd |=> stack_top_pointer_r == $past(spLoadData);
	endproperty
	a_load: assert property (p_load) else $error("pointer load wrong");
	property p_hold;
		spSeen_r && !takeLd && !takePush && !stackRdStb_r |=> $stable(stack_top_pointer_r);
	endproperty
	a_hold: assert property (p_hold) else $error("pointer moved alone");
	property p_busy;
		stackBusy_r |=> !stackWrStb_r && !stackRdStb_r;
	endproperty
	a_busy: assert property (p_busy) else $error("request taken while busy");
	c_push: cover property (takePush && spSeen_r);
	c_pop: cover property (takePop && spSeen_r);
	c_remap: cover property (register_set_select_flag_r && regRdValid_r);
endmodule // reg_remap_chk

bind reg_set_remap_sp reg_remap_chk i_chk(.ref_clk, .arst_n, .pswWrEn, .pswWrData, .status_word_low_byte_r,
	.register_set_select_flag_r, .regReq, .regWr, .regKind, .regCtx, .regSel, .regRdValid_r, .regPhysSel_r,
	.spLoad, .spLoadData, .stack_top_pointer_r, .pushReq, .popReq, .stackWide, .stackAddr_r, .stackWrStb_r,
	.stackRdStb_r, .stackBusy_r);

// ---- tb/tb.sv ----
// Self-checking testbench for the register remap and stack pointer block
`timescale 1ns/100ps
module tb
	import reg_remap_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals, clock, helpers
	// ----------------------------------------------------------------
	logic ref_clk, arst_n, pswWrEn, regReq, regWr, spLoad, pushReq, popReq, stackWide;
	logic [7:0] pswWrData, statusByte;
	operand_kind_t regKind;
	use_ctx_t regCtx;
	logic [3:0] regSel, physSel;
	logic [15:0] regWrData, rdData;
	logic [23:0] spLoadData, sp, stAddr;
	logic flag, rdValid, physWide, wrStb, rdStb, wideOut, busy;
	int miscompares, n_checks;

	reg_set_remap_sp i_dut(.ref_clk(ref_clk), .arst_n(arst_n), .pswWrEn(pswWrEn), .pswWrData(pswWrData),
		.status_word_low_byte_r(statusByte), .register_set_select_flag_r(flag), .regReq(regReq),
		.regWr(regWr), .regKind(regKind), .regCtx(regCtx), .regSel(regSel), .regWrData(regWrData),
		.regRdData_r(rdData), .regRdValid_r(rdValid), .regPhysSel_r(physSel), .regPhysWide_r(physWide),
		.spLoad(spLoad), .spLoadData(spLoadData), .stack_top_pointer_r(sp), .pushReq(pushReq),
		.popReq(popReq), .stackWide(stackWide), .stackAddr_r(stAddr), .stackWrStb_r(wrStb),
		.stackRdStb_r(rdStb), .stackWideOut_r(wideOut), .stackBusy_r(busy));

	// Free-running clock
	initial begin
		ref_clk = 0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Inputs move 1 ns after the edge, never on it
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic do_reset;
		arst_n = 0;
		repeat (20) tick();
		arst_n = 1;
		repeat (3) tick();
	endtask
	task automatic psw(input logic [7:0] d);
		pswWrEn = 1;
		pswWrData = d;
		tick();
		pswWrEn = 0;
		chk(statusByte, d & 8'hFD);
		chk(flag, d[5]);
		tick();
	endtask
	// One access, then an idle cycle so the request never re-rises in the same step
	task automatic acc(input operand_kind_t k, input use_ctx_t c, input logic [3:0] s, input logic w,
		input logic [15:0] d, input logic [3:0] ep, input logic [15:0] er);
		regReq = 1;
		regKind = k;
		regCtx = c;
		regSel = s;
		regWr = w;
		regWrData = d;
		tick();
		regReq = 0;
		chk(physSel, ep);
		chk(physWide, k[0]);
		tick();
		if (!w) begin
			chk(rdValid, 1);
			chk(rdData, er);
		end
	endtask
	task automatic spl(input logic [23:0] d);
		spLoad = 1;
		spLoadData = d;
		tick();
		spLoad = 0;
		chk(sp, d);
		tick();
	endtask
	task automatic sop(input logic p, input logic q, input logic w, input logic [23:0] ea, input logic [23:0] ep);
		pushReq = p;
		popReq = q;
		stackWide = w;
		tick();
		pushReq = 0;
		popReq = 0;
		// Width flips after the take: the pop step must use the width taken
		stackWide = !w;
		chk(wrStb, p);
		chk(rdStb, q);
		chk(busy, 1);
		chk(stAddr, ea);
		chk(wideOut, w);
		tick();
		chk(sp, ep);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk(statusByte, 0);
		chk(flag, 0);
		chk({rdValid, wrStb, rdStb, busy}, 0);
		// Push through a never-loaded pointer must still happen
		pushReq = 1;
		stackWide = 1;
		tick();
		pushReq = 0;
		chk({wrStb, busy}, 2'h3);
		tick();
		$display("reset test done");
	endtask
	task automatic t_remap;
		for (int f = 0; f < 2; f++) begin
			psw(f ? 8'hFF : 8'h00);
			for (int c = 0; c < 3; c++)
				for (int n = 0; n < 4; n++) begin
					acc(OP_FUNC_BYTE, use_ctx_t'(c), 4'(n), 1, 16'(f*64+c*16+n), 4'(n+4*f), 0);
					acc(OP_ABS_BYTE, CTX_OTHER, 4'(n+4*f), 0, 0, 4'(n+4*f), 16'(f*64+c*16+n));
				end
			acc(OP_FUNC_WORD, CTX_EXPLICIT, 4'h1, 1, 16'hA5C3, 4'(1+2*f), 0);
			acc(OP_ABS_WORD, CTX_EXPLICIT, 4'(1+2*f), 0, 0, 4'(1+2*f), 16'hA5C3);
			acc(OP_ABS_BYTE, CTX_EXPLICIT, 4'(3+4*f), 0, 0, 4'(3+4*f), 16'h00A5);
			acc(OP_FUNC_WORD, CTX_IMPLIED, 4'h0, 0, 0, 4'(2*f), 16'((f*64+33)*256+f*64+32));
			acc(OP_FUNC_BYTE, CTX_OTHER, 4'h1, 0, 0, 4'h1, 16'h0021);
			acc(OP_FUNC_BYTE, CTX_INDEX, 4'h4, 1, 16'(f+7), 4'hC, 0);
			acc(OP_ABS_BYTE, CTX_OTHER, 4'hC, 0, 0, 4'hC, 16'(f+7));
		end
		psw(8'h00);
		$display("remap test done");
	endtask
	task automatic t_stack;
		spl(24'h0FEE0);
		sop(1, 0, 1, 24'h0FEDE, 24'h0FEDE);
		sop(1, 0, 0, 24'h0FEDD, 24'h0FEDD);
		sop(0, 1, 0, 24'h0FEDD, 24'h0FEDE);
		sop(0, 1, 1, 24'h0FEDE, 24'h0FEE0);
		// Request held into the busy cycle is taken once only
		pushReq = 1;
		stackWide = 0;
		repeat (2) tick();
		pushReq = 0;
		chk(wrStb, 0);
		chk(sp, 24'h0FEDF);
		tick();
		// Load wins over a simultaneous push
		spLoad = 1;
		spLoadData = 24'h00FE00;
		pushReq = 1;
		tick();
		spLoad = 0;
		pushReq = 0;
		chk(wrStb, 0);
		chk(sp, 24'h00FE00);
		tick();
		sop(1, 0, 0, 24'h00FDFF, 24'h00FDFF);
		$display("stack test done");
	endtask
	task automatic t_rereset;
		psw(8'h20);
		do_reset();
		chk(statusByte, 0);
		acc(OP_FUNC_BYTE, CTX_EXPLICIT, 4'h1, 0, 0, 4'h1, 16'h0021);
		$display("second reset test done");
	endtask

	// Main sequence
	initial begin
		arst_n = 0;
		pswWrEn = 0;
		pswWrData = 0;
		regReq = 0;
		regWr = 0;
		regKind = OP_ABS_BYTE;
		regCtx = CTX_EXPLICIT;
		regSel = 0;
		regWrData = 0;
		spLoad = 0;
		spLoadData = 0;
		pushReq = 0;
		popReq = 0;
		stackWide = 0;
		do_reset();
		t_reset();
		t_remap();
		t_stack();
		t_rereset();
		tally_and_finish();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule // tb
